/* logic/swr_pkg.sv */
/*
 * Package for the single-wire register and flash access block: register map,
 * flash commands, command byte layout, link timing.
 * Assumes a 40 MHz core clock.
 */
package swr_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [6:0] SWR_PAGE0_BASE = 7'h00;
    localparam logic [6:0] SWR_PAGE1_BASE = 7'h20;
    localparam logic [6:0] SWR_PAGE2_BASE = 7'h40;
    localparam logic [6:0] SWR_FLASH_END = 7'h5F;
    localparam logic [6:0] SWR_ADDR_FLASH_COMMAND = 7'h62;
    localparam logic [6:0] SWR_ADDR_COUNTER_CLEAR = 7'h63;
    localparam logic [6:0] SWR_ADDR_PROGRAM_DATA = 7'h6F;
    localparam logic [6:0] SWR_ADDR_PROGRAM_ADDRESS = 7'h70;
    localparam logic [6:0] SWR_ADDR_VOLTAGE_LOW = 7'h71;
    localparam logic [6:0] SWR_ADDR_VOLTAGE_HIGH = 7'h72;
    localparam int SWR_PAGE_BYTES = 32;
    localparam int SWR_FLASH_BYTES = 96;
    localparam logic [7:0] SWR_ERASED = 8'hFF;
    localparam logic [7:0] SWR_ZERO = 8'h00;
    localparam logic [7:0] SWR_CLEAR_MASK = 8'h1F;
    localparam int SWR_CLEAR_DTC_BIT = 3;
    localparam int SWR_CLEAR_CTC_BIT = 4;

    // ****************************************
    // Flash commands
    // ****************************************
    localparam logic [7:0] SWR_CMD_PROGRAM = 8'h0F;
    localparam logic [7:0] SWR_CMD_ERASE0 = 8'h40;
    localparam logic [7:0] SWR_CMD_ERASE1 = 8'h41;
    localparam logic [7:0] SWR_CMD_ERASE2 = 8'h42;
    localparam logic [7:0] SWR_CMD_RAM_TO_FLASH = 8'h45;
    localparam logic [7:0] SWR_CMD_FLASH_TO_RAM = 8'h48;
    localparam logic [7:0] SWR_CMD_POWER_DOWN = 8'hF6;

    // ****************************************
    // Command byte and voltage layout
    // ****************************************
    localparam int SWR_DIR_BIT = 7;
    localparam int SWR_VOLT_BITS = 11;
    localparam int SWR_OFFSET_BITS = 5;

    // ****************************************
    // Link timing (us), cycles at 40 MHz
    // ****************************************
    localparam int SWR_CLK_MHZ = 40;
    localparam int SWR_BREAK_LOW_US = 190;
    localparam int SWR_BREAK_RECOVERY_US = 40;
    localparam int SWR_HOST_SAMPLE_US = 100;
    localparam int SWR_DEVICE_START_LOW_US = 40;
    localparam int SWR_DEVICE_DATA_HOLD_US = 120;
    localparam int SWR_DEVICE_BIT_CYCLE_US = 200;
    localparam int SWR_RESPONSE_DELAY_US = 200;
    localparam int SWR_BREAK_CYC = SWR_BREAK_LOW_US * SWR_CLK_MHZ;
    localparam int SWR_RECOVERY_CYC = SWR_BREAK_RECOVERY_US * SWR_CLK_MHZ;
    localparam int SWR_SAMPLE_CYC = SWR_HOST_SAMPLE_US * SWR_CLK_MHZ;
    localparam int SWR_DSTART_CYC = SWR_DEVICE_START_LOW_US * SWR_CLK_MHZ;
    localparam int SWR_DHOLD_CYC = SWR_DEVICE_DATA_HOLD_US * SWR_CLK_MHZ;
    localparam int SWR_DCYCLE_CYC = SWR_DEVICE_BIT_CYCLE_US * SWR_CLK_MHZ;
    localparam int SWR_TURN_CYC = SWR_RESPONSE_DELAY_US * SWR_CLK_MHZ;
    localparam int SWR_TIMER_W = 14;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic write;
        logic [6:0] index;
        logic [7:0] data;
    } swr_access_s;

    typedef struct packed {
        logic [SWR_VOLT_BITS-1:0] volts;
        logic [SWR_OFFSET_BITS-1:0] offset;
    } swr_voltage_s;
endpackage : swr_pkg

/* logic/swr_fifo.sv */
/*
 * Parameterised valid/ready FIFO for received accesses.
 * Assumes one clock, synchronous to the consumer and producer.
 */
`timescale 1ns/1ps
module swr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;
    logic push, pop;

    always_comb begin
        in_ready_o = (wr_q - rd_q) != (AW+1)'(DEPTH);
        out_valid_o = wr_q != rd_q;
        out_data_o = mem[rd_q[AW-1:0]];
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        wr_d = wr_q + (AW+1)'(push);
        rd_d = rd_q + (AW+1)'(pop);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else if (ce_i) begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    // Storage has no reset so it maps to RAM
    always_ff @(posedge clk_i) begin
        if (ce_i && push) begin
            mem[wr_q[AW-1:0]] <= in_data_i;
        end
    end
endmodule : swr_fifo

/* logic/swr_core.sv */
/*
 * Single-wire return-to-one slave with byte register file, flash model,
 * counter clear and battery voltage registers.
 * Assumes an external pull-up on the line and a 40 MHz clock.
 */
`timescale 1ns/1ps
module swr_core #(
    parameter int BREAK_CYC = swr_pkg::SWR_BREAK_CYC,
    parameter int RECOVERY_CYC = swr_pkg::SWR_RECOVERY_CYC,
    parameter int SAMPLE_CYC = swr_pkg::SWR_SAMPLE_CYC,
    parameter int DSTART_CYC = swr_pkg::SWR_DSTART_CYC,
    parameter int DHOLD_CYC = swr_pkg::SWR_DHOLD_CYC,
    parameter int DCYCLE_CYC = swr_pkg::SWR_DCYCLE_CYC,
    parameter int TURN_CYC = swr_pkg::SWR_TURN_CYC,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic line_i,
    output logic line_o,
    output logic line_oe_o,
    input wire swr_pkg::swr_voltage_s voltage_i,
    input wire logic voltage_valid_i,
    output logic low_power_o,
    output logic [4:0] counter_clear_o,
    output logic slow_discharge_flag_o,
    output logic slow_charge_flag_o,
    input wire logic slow_discharge_set_i,
    input wire logic slow_charge_set_i,
    output logic [7:0] flash_command_reg_o
);
    import swr_pkg::*;

    // ****************************************
    // Link state machine
    // ****************************************
    typedef enum logic [6:0] {
        ST_RECOVER = 7'h01, ST_IDLE = 7'h02, ST_RX_LOW = 7'h04, ST_RX_HIGH = 7'h08,
        ST_TURN = 7'h10, ST_TX_BIT = 7'h20, ST_BREAK = 7'h40
    } swr_link_e;

    logic sync1_q, sync2_q, prev_q;
    swr_link_e st_q, st_d;
    logic [SWR_TIMER_W-1:0] tmr_q, tmr_d, low_q, low_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d, cmd_q, cmd_d, rd_q, rd_d;
    logic have_cmd_q, have_cmd_d, drive_q, drive_d;
    logic push_valid, push_ready, pop_valid, pop_ready;
    swr_access_s push_data, pop_data;

    // ****************************************
    // Register and flash state
    // ****************************************
    logic [7:0] flash_q [SWR_FLASH_BYTES];
    logic [7:0] ram_q [SWR_PAGE_BYTES];
    logic [7:0] flash_command_q, fpd_q, fpa_q, clr_q, flash_command_d, fpd_d, fpa_d, clr_d;
    logic std_q, stc_q, std_d, stc_d, lp_q, lp_d, boot_q, boot_d;
    swr_voltage_s volt_q, volt_d;
    logic [7:0] read_byte;

    function automatic logic [SWR_TIMER_W-1:0] cyc(input int n);
        cyc = SWR_TIMER_W'(n);
    endfunction : cyc

    function automatic logic in_flash(input logic [7:0] a);
        in_flash = a <= {1'b0, SWR_FLASH_END};
    endfunction : in_flash

    // Metastability guard on the pin
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            prev_q <= 1'b1;
        end else if (ce_i) begin
            sync1_q <= line_i;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    always_comb begin
        st_d = st_q;
        tmr_d = tmr_q + cyc(1);
        low_d = sync2_q ? '0 : (low_q == cyc(BREAK_CYC) ? low_q : low_q + cyc(1));
        bit_d = bit_q;
        sh_d = sh_q;
        cmd_d = cmd_q;
        rd_d = rd_q;
        have_cmd_d = have_cmd_q;
        drive_d = 1'b0;
        push_valid = 1'b0;
        push_data = '{write: cmd_q[SWR_DIR_BIT], index: cmd_q[6:0], data: sh_q};
        if (low_q == cyc(BREAK_CYC) && st_q != ST_BREAK) begin
            st_d = ST_BREAK;
            have_cmd_d = 1'b0;
        end else begin
            unique case (st_q)
                ST_BREAK: begin
                    if (sync2_q) begin
                        st_d = ST_RECOVER;
                        tmr_d = '0;
                    end
                end
                ST_RECOVER: begin
                    if (!sync2_q) begin
                        tmr_d = '0;
                    end else if (tmr_q == cyc(RECOVERY_CYC)) begin
                        st_d = ST_IDLE;
                        bit_d = '0;
                    end
                end
                ST_IDLE: begin
                    if (prev_q && !sync2_q) begin
                        st_d = ST_RX_LOW;
                        tmr_d = '0;
                    end
                end
                ST_RX_LOW: begin
                    if (tmr_q == cyc(SAMPLE_CYC)) begin
                        sh_d = {sync2_q, sh_q[7:1]};
                        st_d = ST_RX_HIGH;
                    end
                end
                ST_RX_HIGH: begin
                    if (sync2_q) begin
                        st_d = ST_IDLE;
                        bit_d = bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            if (!have_cmd_q) begin
                                cmd_d = sh_q;
                                if (sh_q[SWR_DIR_BIT]) begin
                                    have_cmd_d = 1'b1;
                                end else begin
                                    st_d = ST_TURN;
                                    tmr_d = '0;
                                end
                            end else begin
                                push_valid = 1'b1;
                                have_cmd_d = 1'b0;
                                if (!push_ready) begin
                                    st_d = ST_RX_HIGH;
                                    bit_d = bit_q;
                                    have_cmd_d = 1'b1;
                                end
                            end
                        end
                    end
                end
                ST_TURN: begin
                    rd_d = read_byte;
                    if (tmr_q == cyc(TURN_CYC)) begin
                        st_d = ST_TX_BIT;
                        tmr_d = '0;
                        bit_d = '0;
                    end
                end
                ST_TX_BIT: begin
                    // Only ever pulls low; high is left to the pull-up
                    drive_d = tmr_q < cyc(DSTART_CYC) ||
                        (tmr_q < cyc(DHOLD_CYC) && !rd_q[0]);
                    if (tmr_q == cyc(DCYCLE_CYC)) begin
                        tmr_d = '0;
                        rd_d = {1'b0, rd_q[7:1]};
                        bit_d = bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            st_d = ST_IDLE;
                            bit_d = '0;
                        end
                    end
                end
                default: st_d = ST_BREAK;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= ST_RECOVER;
            tmr_q <= '0;
            low_q <= '0;
            bit_q <= '0;
            sh_q <= '0;
            cmd_q <= '0;
            rd_q <= '0;
            have_cmd_q <= 1'b0;
            drive_q <= 1'b0;
        end else if (ce_i) begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            low_q <= low_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            cmd_q <= cmd_d;
            rd_q <= rd_d;
            have_cmd_q <= have_cmd_d;
            drive_q <= drive_d;
        end
    end

    // Write accesses queue here so the boot load of page 0 RAM can hold them back
    swr_fifo #(
        .WIDTH($bits(swr_access_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .in_valid_i(push_valid),
        .in_ready_o(push_ready),
        .in_data_i(push_data),
        .out_valid_o(pop_valid),
        .out_ready_i(pop_ready),
        .out_data_o(pop_data)
    );

    // ****************************************
    // Read mux
    // ****************************************
    always_comb begin
        read_byte = SWR_ZERO;
        if (cmd_q[6:0] < SWR_PAGE1_BASE) begin
            read_byte = ram_q[cmd_q[4:0]];
        end else if (in_flash({1'b0, cmd_q[6:0]})) begin
            read_byte = flash_q[cmd_q[6:0]];
        end else begin
            unique case (cmd_q[6:0])
                SWR_ADDR_FLASH_COMMAND: read_byte = flash_command_q;
                SWR_ADDR_COUNTER_CLEAR: read_byte = clr_q;
                SWR_ADDR_PROGRAM_DATA: read_byte = fpd_q;
                SWR_ADDR_PROGRAM_ADDRESS: read_byte = fpa_q;
                SWR_ADDR_VOLTAGE_LOW: read_byte = volt_q.volts[7:0];
                SWR_ADDR_VOLTAGE_HIGH: read_byte = {volt_q.offset, volt_q.volts[10:8]};
                default: read_byte = SWR_ZERO;
            endcase
        end
    end

    // ****************************************
    // Register writes and control
    // ****************************************
    always_comb begin
        flash_command_d = flash_command_q;
        fpd_d = fpd_q;
        fpa_d = fpa_q;
        // Clear completes in one cycle, so the bits self-return next cycle
        clr_d = SWR_ZERO;
        std_d = std_q | slow_discharge_set_i;
        stc_d = stc_q | slow_charge_set_i;
        lp_d = lp_q && sync2_q;
        boot_d = 1'b0;
        volt_d = voltage_valid_i ? voltage_i : volt_q;
        // Hold the queue during the boot cycle while page 0 RAM loads from flash
        pop_ready = !boot_q;
        // A rollover landing with the clear still sets the flag
        if (clr_q[SWR_CLEAR_DTC_BIT]) begin
            std_d = slow_discharge_set_i;
        end
        if (clr_q[SWR_CLEAR_CTC_BIT]) begin
            stc_d = slow_charge_set_i;
        end
        if (pop_valid && pop_ready && pop_data.write) begin
            unique case (pop_data.index)
                SWR_ADDR_FLASH_COMMAND: begin
                    flash_command_d = pop_data.data;
                    if (pop_data.data == SWR_CMD_POWER_DOWN) begin
                        lp_d = 1'b1;
                    end
                end
                SWR_ADDR_COUNTER_CLEAR: clr_d = pop_data.data & SWR_CLEAR_MASK;
                SWR_ADDR_PROGRAM_DATA: fpd_d = pop_data.data;
                SWR_ADDR_PROGRAM_ADDRESS: fpa_d = pop_data.data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            flash_command_q <= SWR_ZERO;
            fpd_q <= SWR_ERASED;
            fpa_q <= SWR_ZERO;
            clr_q <= SWR_ZERO;
            std_q <= 1'b0;
            stc_q <= 1'b0;
            lp_q <= 1'b0;
            boot_q <= 1'b1;
            volt_q <= '0;
        end else if (ce_i) begin
            flash_command_q <= flash_command_d;
            fpd_q <= fpd_d;
            fpa_q <= fpa_d;
            clr_q <= clr_d;
            std_q <= std_d;
            stc_q <= stc_d;
            lp_q <= lp_d;
            boot_q <= boot_d;
            volt_q <= volt_d;
        end
    end

    // ****************************************
    // Flash and page 0 RAM
    // ****************************************
    // Flash array is left unreset: contents are nonvolatile across reset
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            for (int i = 0; i < SWR_PAGE_BYTES; i++) begin
                if (boot_q) begin
                    ram_q[i] <= flash_q[i];
                end
            end
            if (pop_valid && pop_ready && pop_data.write) begin
                if (pop_data.index < SWR_PAGE1_BASE) begin
                    ram_q[pop_data.index[4:0]] <= pop_data.data;
                end
                if (pop_data.index == SWR_ADDR_FLASH_COMMAND) begin
                    unique case (pop_data.data)
                        SWR_CMD_PROGRAM: begin
                            if (in_flash(fpa_q)) begin
                                flash_q[fpa_q[6:0]] <= flash_q[fpa_q[6:0]] & fpd_q;
                            end
                        end
                        SWR_CMD_ERASE0, SWR_CMD_ERASE1, SWR_CMD_ERASE2: begin
                            for (int i = 0; i < SWR_PAGE_BYTES; i++) begin
                                flash_q[{pop_data.data[1:0], 5'(i)}] <= SWR_ERASED;
                            end
                        end
                        SWR_CMD_RAM_TO_FLASH: begin
                            for (int i = 0; i < SWR_PAGE_BYTES; i++) begin
                                flash_q[i] <= flash_q[i] & ram_q[i];
                            end
                        end
                        SWR_CMD_FLASH_TO_RAM: begin
                            for (int i = 0; i < SWR_PAGE_BYTES; i++) begin
                                ram_q[i] <= flash_q[i];
                            end
                        end
                        default: ;
                    endcase
                end
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            line_o <= 1'b0;
            line_oe_o <= 1'b0;
            low_power_o <= 1'b0;
            counter_clear_o <= '0;
            slow_discharge_flag_o <= 1'b0;
            slow_charge_flag_o <= 1'b0;
            flash_command_reg_o <= SWR_ZERO;
        end else if (ce_i) begin
            line_o <= 1'b0;
            line_oe_o <= drive_d;
            low_power_o <= lp_d;
            counter_clear_o <= clr_d[4:0];
            slow_discharge_flag_o <= std_d;
            slow_charge_flag_o <= stc_d;
            flash_command_reg_o <= flash_command_d;
        end
    end
endmodule : swr_core

/* dv/swr_core_checker.sv */
/* Port checker for swr_core. Assumes ce_i high and bind-supplied timing. */
`timescale 1ns/1ps
module swr_core_checker #(
    parameter int DSTART_CYC = 4,
    parameter int DHOLD_CYC = 12
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic line_i,
    input wire logic line_o,
    input wire logic line_oe_o,
    input wire logic low_power_o,
    input wire logic [4:0] counter_clear_o,
    input wire logic slow_discharge_flag_o,
    input wire logic slow_charge_flag_o,
    input wire logic [7:0] flash_command_reg_o
);
    import swr_pkg::*;
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    line_low_only_a: assert property (line_o == 1'b0)
        else $error("line data not low");
    start_low_a: assert property ($rose(line_oe_o) |-> line_oe_o [*4])
        else $error("device start low too short");
    hold_end_a: assert property ($rose(line_oe_o) |-> ##[DSTART_CYC:DHOLD_CYC] $fell(line_oe_o))
        else $error("device low time out of range");
    tail_high_a: assert property ($fell(line_oe_o) |-> !line_oe_o [*8])
        else $error("device bit tail too short");
    clear_pulse_a: assert property (|counter_clear_o |=> counter_clear_o == 5'h00)
        else $error("clear bit not self clearing");
    dis_flag_clr_a: assert property (counter_clear_o[3] |-> ##[0:1] !slow_discharge_flag_o)
        else $error("discharge slow flag kept");
    chg_flag_clr_a: assert property (counter_clear_o[4] |-> ##[0:1] !slow_charge_flag_o)
        else $error("charge slow flag kept");
    sleep_cause_a: assert property ($rose(low_power_o) |-> flash_command_reg_o == SWR_CMD_POWER_DOWN)
        else $error("low power without command");
    sleep_wake_a: assert property (low_power_o && !line_i |-> ##[1:5] !low_power_o)
        else $error("low power not left");
endmodule : swr_core_checker

bind swr_core swr_core_checker #(.DSTART_CYC(DSTART_CYC), .DHOLD_CYC(DHOLD_CYC)) swr_core_checker_inst (
    .clk_i(clk_i), .rst_i(rst_i), .line_i(line_i), .line_o(line_o), .line_oe_o(line_oe_o),
    .low_power_o(low_power_o), .counter_clear_o(counter_clear_o),
    .slow_discharge_flag_o(slow_discharge_flag_o), .slow_charge_flag_o(slow_charge_flag_o),
    .flash_command_reg_o(flash_command_reg_o));

/* dv/swr_host.sv */
/* Host model driving the single wire line low only. Assumes scaled timing. */
`timescale 1ns/1ps
module swr_host (
    input wire logic clk_i,
    input wire logic line_i,
    output logic pull_o
);
    initial pull_o = 1'b0;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    // Scaled 30 cycle bit, far below the real rate limit
    task automatic send_bit(input logic b);
        pull_o = 1'b1;
        tick(b ? 4 : 16);
        pull_o = 1'b0;
        tick(b ? 26 : 14);
    endtask : send_bit
    task automatic send_byte(input logic [7:0] d);
        for (int i = 0; i < 8; i++) send_bit(d[i]);
    endtask : send_byte
    task automatic send_break();
        pull_o = 1'b1;
        tick(48);
        pull_o = 1'b0;
        tick(12);
    endtask : send_break
    task automatic recv_byte(output logic [7:0] d, output bit ok);
        int n;
        ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            n = 0;
            while (line_i && n < 200) begin tick(1); n++; end
            if (n >= 200) begin ok = 1'b0; return; end
            n = 0;
            while (!line_i && n < 40) begin tick(1); n++; end
            d[i] = (n < 8);
        end
    endtask : recv_byte
endmodule : swr_host

/* dv/single_wire_register_flash_access_tb.sv */
/* Testbench for swr_core through its line. Assumes swr_host as the far side. */
`timescale 1ns/1ps
module single_wire_register_flash_access_tb;
    import swr_pkg::*;
    logic clk = 1'b0, rst = 1'b1, vv = 1'b0, sd = 1'b0, sc = 1'b0, ce = 1'b1;
    logic pull, oe, lo, lp, sdf, scf, lvl;
    swr_voltage_s volt = '0;
    logic [4:0] cc;
    logic [7:0] fcr, rv;
    int num_errors = 0, check_count = 0;
    // Wired-and of both parties
    assign lvl = !pull && !(oe && !lo);
    swr_core #(.BREAK_CYC(40), .RECOVERY_CYC(8), .SAMPLE_CYC(10), .DSTART_CYC(4),
        .DHOLD_CYC(12), .DCYCLE_CYC(20), .TURN_CYC(20)) swr_core_inst (
        .clk_i(clk), .rst_i(rst), .ce_i(ce), .line_i(lvl), .line_o(lo), .line_oe_o(oe),
        .voltage_i(volt), .voltage_valid_i(vv), .low_power_o(lp), .counter_clear_o(cc),
        .slow_discharge_flag_o(sdf), .slow_charge_flag_o(scf),
        .slow_discharge_set_i(sd), .slow_charge_set_i(sc), .flash_command_reg_o(fcr));
    swr_host swr_host_inst (.clk_i(clk), .line_i(lvl), .pull_o(pull));
    initial forever #12.5 clk = ~clk;
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        swr_host_inst.send_byte({1'b1, a});
        swr_host_inst.send_byte(d);
        swr_host_inst.tick(8);
    endtask : wr
    task automatic rchk(input logic [6:0] a, input logic [7:0] exp, input string what);
        bit ok;
        swr_host_inst.send_byte({1'b0, a});
        swr_host_inst.recv_byte(rv, ok);
        if (!ok) begin num_errors++; $display("[ERR] %0t no reply", $time); tally_and_finish(); end
        chk(rv, exp, what);
        // Device bit tail outlasts the visible low; wait it out
        swr_host_inst.tick(24);
    endtask : rchk
    task automatic pulse(ref logic s);
        s = 1'b1;
        swr_host_inst.tick(1);
        s = 1'b0;
        swr_host_inst.tick(2);
    endtask : pulse
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        $display("[ERR] %0t timeout", $time);
        tally_and_finish();
    end
    initial begin
        swr_host_inst.tick(6);
        rst = 1'b0;
        chk({oe, lp, sdf, scf, cc}, 8'h00, "reset outputs");
        swr_host_inst.send_break();
        wr(7'h6F, 8'hA5);
        rchk(7'h6F, 8'hA5, "data reg");
        rchk(7'h7A, 8'h00, "unmapped");
        swr_host_inst.send_byte(8'hEF);
        for (int i = 0; i < 3; i++) swr_host_inst.send_bit(1'b0);
        swr_host_inst.send_break();
        rchk(7'h6F, 8'hA5, "aborted write");
        $display("test link done");
        wr(7'h62, SWR_CMD_ERASE1);
        wr(7'h62, SWR_CMD_ERASE2);
        rchk(7'h20, 8'hFF, "erase1");
        rchk(7'h5F, 8'hFF, "erase2");
        wr(7'h6F, 8'h3C);
        wr(7'h70, 8'h21);
        wr(7'h62, SWR_CMD_PROGRAM);
        chk(fcr, SWR_CMD_PROGRAM, "command reg");
        rchk(7'h21, 8'h3C, "program");
        wr(7'h6F, 8'hF0);
        wr(7'h62, SWR_CMD_PROGRAM);
        rchk(7'h21, 8'h30, "program and");
        rchk(7'h20, 8'hFF, "neighbour");
        wr(7'h05, 8'h5A);
        wr(7'h62, SWR_CMD_ERASE0);
        wr(7'h62, SWR_CMD_RAM_TO_FLASH);
        wr(7'h05, 8'h00);
        wr(7'h62, SWR_CMD_FLASH_TO_RAM);
        rchk(7'h05, 8'h5A, "page transfer");
        $display("test flash done");
        volt = '{volts: 11'h5A3, offset: 5'h13};
        pulse(vv);
        rchk(7'h71, 8'hA3, "volt low");
        rchk(7'h72, 8'h9D, "volt high");
        ce = 1'b0;
        pulse(sd);
        ce = 1'b1;
        chk({sdf, scf}, 8'h00, "frozen by enable");
        pulse(sd);
        pulse(sc);
        chk({sdf, scf}, 8'h03, "slow flags");
        wr(7'h63, 8'h08);
        chk({sdf, scf}, 8'h01, "dis clear");
        wr(7'h63, 8'h10);
        chk({sdf, scf}, 8'h00, "chg clear");
        rchk(7'h63, 8'h00, "clear self");
        wr(7'h62, SWR_CMD_POWER_DOWN);
        chk(lp, 1'b1, "power down");
        swr_host_inst.send_bit(1'b1);
        chk(lp, 1'b0, "wake on line");
        $display("test misc done");
        tally_and_finish();
    end
endmodule : single_wire_register_flash_access_tb
